/* File: hw/instr_exec_pkg.sv */
// Constants, types and register map for the OR / move / pointer-load execute block.
// Assumes a core that supplies one instruction word per four-phase cycle and a
// data memory that answers a read within the cycle the read strobe stands.
`default_nettype none

package instr_exec_pkg;

  // ----------------------------------------------------------------------
  // Quarter phases of one instruction cycle
  // ----------------------------------------------------------------------
  localparam logic [1:0] PH_DECODE  = 2'h0;
  localparam logic [1:0] PH_READ    = 2'h1;
  localparam logic [1:0] PH_PROCESS = 2'h2;
  localparam logic [1:0] PH_WRITE   = 2'h3;

  // ----------------------------------------------------------------------
  // Opcode patterns and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_OR_LIT     = 8'h09;
  localparam logic [5:0] OPC_OR_FILE    = 6'h04;
  localparam logic [5:0] OPC_COPY_FILE  = 6'h14;
  localparam logic [7:0] OPC_PTR_FIRST  = 8'hEE;
  localparam logic [1:0] OPC_PTR_ZERO   = 2'h0;
  localparam logic [7:0] OPC_PTR_SECOND = 8'hF0;
  localparam logic [3:0] OPC_F2F_SRC    = 4'hC;
  localparam logic [3:0] OPC_F2F_DST    = 4'hF;
  localparam int         DEST_BIT       = 9;
  localparam int         ACCESS_BIT     = 8;
  localparam logic [1:0] PTR_COUNT      = 2'h3;
  localparam logic [7:0] INDEXED_LIMIT  = 8'h5F;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam int         INDEX_PTR      = 2;

  // ----------------------------------------------------------------------
  // Status layout
  // ----------------------------------------------------------------------
  localparam int         STATUS_N_BIT   = 4;
  localparam int         STATUS_Z_BIT   = 2;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_ACC     = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_BANK    = 8'h0C;
  localparam logic [7:0] REG_PTR0    = 8'h10;
  localparam logic [7:0] REG_PTR1    = 8'h14;
  localparam logic [7:0] REG_PTR2    = 8'h18;
  localparam logic [7:0] REG_STATE   = 8'h1C;
  localparam int         CTRL_RUN    = 0;
  localparam int         CTRL_EXT    = 1;
  localparam logic [1:0] CTRL_RESET  = 2'h0;
  localparam logic [7:0] ACC_RESET   = 8'h00;
  localparam logic [4:0] STAT_RESET  = 5'h00;
  localparam logic [3:0] BANK_RESET  = 4'h0;
  localparam logic [11:0] PTR_RESET  = 12'h000;

  typedef enum logic [1:0] {
    ST_EXEC    = 2'b00,
    ST_PTR_LOW = 2'b01,
    ST_F2F_DST = 2'b10
  } exec_state_e;

  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } mem_req_s;

endpackage : instr_exec_pkg

`default_nettype wire

/* File: hw/or_move_pointer_instr_exec.sv */
// Execute logic for literal/register OR, register copy, pointer load and file-to-file copy.
// Assumes one instruction word presented during each decode phase, a data memory that
// returns read data combinationally while the read strobe stands, and a plain register port.
//
// What this block does
// - Opcode 0000 1001 ORs the accumulator with the 8-bit literal into the accumulator.
// - Prefix 0001 00 ORs the accumulator with the addressed register, destination bit normally one.
// - Destination bit zero sends the result to the accumulator, one sends it back to the register.
// - Literal OR, register OR and register copy update only negative and zero flags.
// - Access bit zero maps the address into the access bank, one uses the bank select register.
// - With access bit zero, extended set on and address at most 95, indexed offset addressing is used.
// - Pointer load takes two words and cycles, high nibble then low byte, no flags change.
// - Prefix 0101 00 copies the addressed register to the destination the destination bit picks.
// - The 8-bit address of the OR and copy reaches every location of the selected 256-byte bank.
// - File-to-file copy is words 1100 source then 1111 destination and changes no flags.
// - Both file-to-file addresses span the whole 4096-byte space without bank selection.
// - File-to-file copy reads the source in cycle one and writes in the last quarter of cycle two.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`default_nettype none

module or_move_pointer_instr_exec (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic [15:0]               instr_word,
  output logic                           instr_taken_q,
  output instr_exec_pkg::mem_req_s       mem_req_q,
  input  wire logic [7:0]                mem_rdata,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [31:0]                    reg_rdata_q
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  instr_exec_pkg::exec_state_e state_q;
  instr_exec_pkg::exec_state_e state_d;
  logic [1:0]  phase_q;
  logic [1:0]  ctrl_q;
  logic [7:0]  acc_q;
  logic [4:0]  status_q;
  logic [3:0]  bank_q;
  logic [11:0] ptr_q [3];
  logic [15:0] word_q;
  logic [1:0]  ptr_idx_q;
  logic [7:0]  res_q;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire run        = ctrl_q[instr_exec_pkg::CTRL_RUN];
  wire ext_en     = ctrl_q[instr_exec_pkg::CTRL_EXT];
  wire in_exec    = (state_q == instr_exec_pkg::ST_EXEC);
  wire in_ptr_low = (state_q == instr_exec_pkg::ST_PTR_LOW);
  wire in_f2f_dst = (state_q == instr_exec_pkg::ST_F2F_DST);
  wire ph_decode  = run && (phase_q == instr_exec_pkg::PH_DECODE);
  wire ph_read    = run && (phase_q == instr_exec_pkg::PH_READ);
  wire ph_process = run && (phase_q == instr_exec_pkg::PH_PROCESS);
  wire ph_write   = run && (phase_q == instr_exec_pkg::PH_WRITE);

  wire op_or_lit  = in_exec && (word_q[15:8] == instr_exec_pkg::OPC_OR_LIT);
  wire op_or_file = in_exec && (word_q[15:10] == instr_exec_pkg::OPC_OR_FILE);
  wire op_copy    = in_exec && (word_q[15:10] == instr_exec_pkg::OPC_COPY_FILE);
  wire op_ptr_hi  = in_exec && (word_q[15:8] == instr_exec_pkg::OPC_PTR_FIRST)
                    && (word_q[7:6] == instr_exec_pkg::OPC_PTR_ZERO)
                    && (word_q[5:4] != instr_exec_pkg::PTR_COUNT);
  wire op_f2f_src = in_exec && (word_q[15:12] == instr_exec_pkg::OPC_F2F_SRC);
  wire op_file    = op_or_file || op_copy;
  wire op_logic   = op_or_lit || op_file;
  wire dest_file  = word_q[instr_exec_pkg::DEST_BIT];
  wire access_bsr = word_q[instr_exec_pkg::ACCESS_BIT];
  wire [7:0] faddr = word_q[7:0];

  // ----------------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------------
  wire use_indexed = !access_bsr && ext_en && (faddr <= instr_exec_pkg::INDEXED_LIMIT);
  wire [11:0] idx_addr  = ptr_q[instr_exec_pkg::INDEX_PTR] + {4'h0, faddr};
  wire [3:0]  acc_bank  = (faddr <= instr_exec_pkg::INDEXED_LIMIT) ?
                          instr_exec_pkg::ACCESS_LO_BANK : instr_exec_pkg::ACCESS_HI_BANK;
  wire [11:0] bank_addr = access_bsr ? {bank_q, faddr} : {acc_bank, faddr};
  wire [11:0] file_addr = use_indexed ? idx_addr : bank_addr;

  // ----------------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------------
  wire [7:0] operand  = op_or_lit ? word_q[7:0] : mem_rdata;
  wire [7:0] result_d = op_copy ? operand : (acc_q | operand);
  wire commit_acc   = ph_write && (op_or_lit || (op_file && !dest_file));
  wire commit_flags = ph_write && op_logic;
  wire [4:0] flags_d = {res_q[7], status_q[3], (res_q == 8'h00), status_q[1:0]};

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  wire wr_ctrl   = reg_wr && (reg_addr == instr_exec_pkg::REG_CTRL);
  wire wr_acc    = reg_wr && (reg_addr == instr_exec_pkg::REG_ACC);
  wire wr_status = reg_wr && (reg_addr == instr_exec_pkg::REG_STATUS);
  wire wr_bank   = reg_wr && (reg_addr == instr_exec_pkg::REG_BANK);
  wire [2:0] wr_ptr = {reg_wr && (reg_addr == instr_exec_pkg::REG_PTR2),
                       reg_wr && (reg_addr == instr_exec_pkg::REG_PTR1),
                       reg_wr && (reg_addr == instr_exec_pkg::REG_PTR0)};
  wire [31:0] rd_mux =
    (reg_addr == instr_exec_pkg::REG_CTRL)   ? {30'h0, ctrl_q} :
    (reg_addr == instr_exec_pkg::REG_ACC)    ? {24'h0, acc_q} :
    (reg_addr == instr_exec_pkg::REG_STATUS) ? {27'h0, status_q} :
    (reg_addr == instr_exec_pkg::REG_BANK)   ? {28'h0, bank_q} :
    (reg_addr == instr_exec_pkg::REG_PTR0)   ? {20'h0, ptr_q[0]} :
    (reg_addr == instr_exec_pkg::REG_PTR1)   ? {20'h0, ptr_q[1]} :
    (reg_addr == instr_exec_pkg::REG_PTR2)   ? {20'h0, ptr_q[2]} :
    (reg_addr == instr_exec_pkg::REG_STATE)  ? {28'h0, state_q, phase_q} : 32'h0;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    case (state_q)
      instr_exec_pkg::ST_EXEC: begin
        if (op_ptr_hi) begin
          state_d = instr_exec_pkg::ST_PTR_LOW;
        end else if (op_f2f_src) begin
          state_d = instr_exec_pkg::ST_F2F_DST;
        end else begin
          state_d = instr_exec_pkg::ST_EXEC;
        end
      end
      instr_exec_pkg::ST_PTR_LOW: state_d = instr_exec_pkg::ST_EXEC;
      instr_exec_pkg::ST_F2F_DST: state_d = instr_exec_pkg::ST_EXEC;
      default:                    state_d = instr_exec_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= instr_exec_pkg::PH_DECODE;
      state_q <= instr_exec_pkg::ST_EXEC;
    end else if (run) begin
      phase_q <= phase_q + 2'h1;
      if (ph_write) begin
        state_q <= state_d;
      end
    end
  end

  // Each word is taken at the end of the decode phase; the pointer index of the
  // first load word is kept because the second word does not carry it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_q        <= 16'h0000;
      ptr_idx_q     <= 2'h0;
      instr_taken_q <= 1'b0;
    end else begin
      instr_taken_q <= ph_decode;
      if (ph_decode) begin
        word_q <= instr_word;
      end
      if (op_ptr_hi && ph_write) begin
        ptr_idx_q <= word_q[5:4];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Data memory strobes
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_q <= '0;
      res_q     <= 8'h00;
    end else begin
      mem_req_q.rd <= ph_read && (op_file || op_f2f_src);
      mem_req_q.wr <= ph_process && ((op_file && dest_file) || in_f2f_dst);
      if (ph_read && op_file) begin
        mem_req_q.addr <= file_addr;
      end else if (ph_read && op_f2f_src) begin
        mem_req_q.addr <= word_q[11:0];
      end else if (ph_process && in_f2f_dst) begin
        mem_req_q.addr <= word_q[11:0];
      end
      if (ph_process && in_exec) begin
        res_q <= op_f2f_src ? mem_rdata : result_d;
      end
      if (ph_process) begin
        mem_req_q.wdata <= in_f2f_dst ? res_q : result_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Architectural registers; a software write in the same cycle as a core
  // write wins, since software is assumed to halt the core before editing.
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= instr_exec_pkg::CTRL_RESET;
      acc_q    <= instr_exec_pkg::ACC_RESET;
      status_q <= instr_exec_pkg::STAT_RESET;
      bank_q   <= instr_exec_pkg::BANK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[1:0];
      end
      if (wr_acc) begin
        acc_q <= reg_wdata[7:0];
      end else if (commit_acc) begin
        acc_q <= res_q;
      end
      if (wr_status) begin
        status_q <= reg_wdata[4:0];
      end else if (commit_flags) begin
        status_q <= flags_d;
      end
      if (wr_bank) begin
        bank_q <= reg_wdata[3:0];
      end
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_ptr
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ptr_q[i] <= instr_exec_pkg::PTR_RESET;
      end else if (wr_ptr[i]) begin
        ptr_q[i] <= reg_wdata[11:0];
      end else if (ph_write && op_ptr_hi && (word_q[5:4] == 2'(i))) begin
        ptr_q[i][11:8] <= word_q[3:0];
      end else if (ph_write && in_ptr_low && (ptr_idx_q == 2'(i))) begin
        ptr_q[i][7:0] <= word_q[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  localparam int F2F_MIN = 5;
  localparam int F2F_MAX = 6;

  property p_or_literal;
    @(posedge ref_clk) disable iff (!rst_n)
    (ph_write && op_or_lit && !wr_acc) |=> (acc_q == ($past(acc_q) | $past(word_q[7:0])));
  endproperty
  a_or_literal: assert property (p_or_literal) else $error("literal OR result wrong");

  property p_or_file_dest;
    @(posedge ref_clk) disable iff (!rst_n)
    (ph_process && op_or_file && dest_file)
      |=> (mem_req_q.wr && mem_req_q.wdata == ($past(acc_q) | $past(mem_rdata)));
  endproperty
  a_or_file_dest: assert property (p_or_file_dest) else $error("register OR write wrong");

  property p_dest_acc;
    @(posedge ref_clk) disable iff (!rst_n)
    (ph_process && op_file && !dest_file) |=> !mem_req_q.wr ##1 (wr_acc || acc_q == $past(res_q));
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination wrong");

  property p_flags;
    @(posedge ref_clk) disable iff (!rst_n)
    (ph_write && op_logic && !wr_status) |=> (status_q[3] == $past(status_q[3]))
      && (status_q[1:0] == $past(status_q[1:0]))
      && (status_q[instr_exec_pkg::STATUS_Z_BIT] == ($past(res_q) == 8'h00))
      && (status_q[instr_exec_pkg::STATUS_N_BIT] == $past(res_q[7]));
  endproperty
  a_flags: assert property (p_flags) else $error("status flag update wrong");

  property p_bank_addr;
    @(posedge ref_clk) disable iff (!rst_n)
    (ph_read && op_file && access_bsr) |=> (mem_req_q.addr == {$past(bank_q), $past(faddr)});
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");

  property p_indexed_addr;
    @(posedge ref_clk) disable iff (!rst_n)
    (ph_read && op_file && !access_bsr && ext_en && faddr <= 8'h5F)
      |=> (mem_req_q.addr == $past(ptr_q[2] + {4'h0, faddr}));
  endproperty
  a_indexed_addr: assert property (p_indexed_addr) else $error("indexed address wrong");

  property p_ptr_load;
    @(posedge ref_clk) disable iff (!rst_n)
    (ph_write && op_ptr_hi && word_q[5:4] == 2'h0 && wr_ptr == 3'h0)
      |=> (ptr_q[0][11:8] == $past(word_q[3:0])) ##3 (in_ptr_low || !run);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer load sequence wrong");

  property p_f2f_write;
    @(posedge ref_clk) disable iff (!rst_n)
    (ph_read && op_f2f_src && run) |=> mem_req_q.rd ##[F2F_MIN:F2F_MAX] (mem_req_q.wr || !run);
  endproperty
  a_f2f_write: assert property (p_f2f_write) else $error("copy write not in time");

  property p_phase_order;
    @(posedge ref_clk) disable iff (!rst_n)
    (run && phase_q == instr_exec_pkg::PH_DECODE && $past(run)) [*1] ##0 ctrl_q == $past(ctrl_q)
      |=> (phase_q == instr_exec_pkg::PH_READ);
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order wrong");

  c_or_literal: cover property (@(posedge ref_clk) disable iff (!rst_n) ph_write && op_or_lit);
  c_ptr_load:   cover property (@(posedge ref_clk) disable iff (!rst_n) ph_write && in_ptr_low);
  c_f2f:        cover property (@(posedge ref_clk) disable iff (!rst_n) mem_req_q.wr && in_f2f_dst);
  c_indexed:    cover property (@(posedge ref_clk) disable iff (!rst_n) ph_read && use_indexed);

endmodule : or_move_pointer_instr_exec

`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the OR, copy, pointer-load and file-to-file execute block.
// Assumes the block's plain register port and a data memory modelled here that answers
// a read at once, in the same cycle as the read strobe.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals, clock and the data memory beside the block
  // ----------------------------------------------------------------------
  logic                     ref_clk   = 1'b0;
  logic                     rst_n     = 1'b0;
  logic [15:0]              instr_word;
  logic                     instr_taken_q;
  instr_exec_pkg::mem_req_s mem_req_q;
  logic [7:0]               mem_rdata;
  logic [7:0]               reg_addr  = 8'h00;
  logic [31:0]              reg_wdata = 32'h0000_0000;
  logic                     reg_wr    = 1'b0;
  logic                     reg_rd    = 1'b0;
  logic [31:0]              reg_rdata_q;
  logic [7:0]               mem [4096];
  logic [15:0]              prog [16];
  logic [3:0]               pc        = 4'h0;
  logic [11:0]              wr_addr;
  int                       cyc       = 0;
  int                       taken_cyc = 0;
  int                       rd_cyc    = 0;
  int                       wr_lag    = 0;
  int                       wr_gap    = 0;
  int                       n_words   = 0;
  int                       error_cnt = 0;
  int                       checks    = 0;

  always #5 ref_clk = ~ref_clk;

  assign instr_word = prog[pc];
  assign mem_rdata  = mem[mem_req_q.addr];

  // The fetch side moves on only when the block says it took a word.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (!rst_n) begin
      pc <= 4'h0;
    end else if (instr_taken_q === 1'b1) begin
      pc        <= pc + 4'h1;
      taken_cyc <= cyc;
    end
    if (mem_req_q.rd === 1'b1) begin
      rd_cyc <= cyc;
    end
    if (mem_req_q.wr === 1'b1) begin
      wr_addr             <= mem_req_q.addr;
      wr_lag              <= cyc - taken_cyc;
      wr_gap              <= cyc - rd_cyc;
      mem[mem_req_q.addr] <= mem_req_q.wdata;
    end
  end

  or_move_pointer_instr_exec or_move_pointer_instr_exec_inst (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .instr_word    (instr_word),
    .instr_taken_q (instr_taken_q),
    .mem_req_q     (mem_req_q),
    .mem_rdata     (mem_rdata),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata_q   (reg_rdata_q)
  );

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(what, exp, reg_rdata_q);
  endtask : reg_check

  // Reset also rewinds the program, so every scenario starts at phase zero.
  task automatic do_reset;
    rst_n   <= 1'b0;
    n_words = 0;
    for (int i = 0; i < 16; i++) begin
      prog[i] = 16'h0000;
    end
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic put(input logic [15:0] w);
    prog[n_words] = w;
    n_words++;
  endtask : put

  // Runs until every word was taken, lets the last one finish, then stops the core.
  task automatic run_prog(input logic [1:0] ctrl);
    int i;
    reg_write(instr_exec_pkg::REG_CTRL, {30'h0, ctrl});
    for (i = 0; i < 200 && pc != 4'(n_words); i++) begin
      @(posedge ref_clk);
    end
    if (i == 200) begin
      error_cnt++;
      $display("Error program words taken expected %0d seen %0d", n_words, pc);
      end_of_test;
    end
    repeat (8) @(posedge ref_clk);
    reg_write(instr_exec_pkg::REG_CTRL, 32'h0000_0000);
  endtask : run_prog

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'h00;
    end
    do_reset;
    for (int a = 0; a <= 32; a += 4) begin
      reg_check("register after reset", 8'(a), 32'h0000_0000);
    end
    reg_write(instr_exec_pkg::REG_ACC, 32'h0000_009A);
    reg_write(instr_exec_pkg::REG_STATUS, 32'h0000_000B);
    put(16'h0935);
    run_prog(2'b01);
    reg_check("acc after literal or", instr_exec_pkg::REG_ACC, 32'h0000_00BF);
    reg_check("status after literal or", instr_exec_pkg::REG_STATUS, 32'h0000_001B);

    do_reset;
    mem[12'h3FF] = 8'h13;
    mem[12'h300] = 8'h55;
    mem[12'h000] = 8'h00;
    reg_write(instr_exec_pkg::REG_BANK, 32'h0000_0003);
    reg_write(instr_exec_pkg::REG_ACC, 32'h0000_0091);
    reg_write(instr_exec_pkg::REG_STATUS, 32'h0000_000B);
    put(16'h13FF);
    put(16'h5000);
    run_prog(2'b01);
    chk("register or written back", 32'h0000_0093, {24'h0, mem[12'h3FF]});
    chk("bank write address", 32'h0000_03FF, {20'h0, wr_addr});
    chk("write slot after take", 32'h0000_0002, 32'(wr_lag));
    reg_check("acc after copy", instr_exec_pkg::REG_ACC, 32'h0000_0000);
    reg_check("status after copy", instr_exec_pkg::REG_STATUS, 32'h0000_000F);

    do_reset;
    mem[12'h205] = 8'h80;
    mem[12'hF60] = 8'h7E;
    reg_write(instr_exec_pkg::REG_PTR2, 32'h0000_0200);
    put(16'h5205);
    put(16'h5060);
    run_prog(2'b11);
    chk("indexed write address", 32'h0000_0205, {20'h0, wr_addr});
    chk("indexed copy back", 32'h0000_0080, {24'h0, mem[12'h205]});
    reg_check("acc from access bank", instr_exec_pkg::REG_ACC, 32'h0000_007E);
    reg_check("status after copies", instr_exec_pkg::REG_STATUS, 32'h0000_0000);

    do_reset;
    mem[12'hFFF] = 8'h33;
    mem[12'h000] = 8'h11;
    reg_write(instr_exec_pkg::REG_STATUS, 32'h0000_001F);
    put(16'hEE23);
    put(16'hF0AB);
    put(16'hEE0F);
    put(16'hF0FF);
    put(16'hCFFF);
    put(16'hF000);
    run_prog(2'b01);
    reg_check("pointer two", instr_exec_pkg::REG_PTR2, 32'h0000_03AB);
    reg_check("pointer zero", instr_exec_pkg::REG_PTR0, 32'h0000_0FFF);
    reg_check("pointer one", instr_exec_pkg::REG_PTR1, 32'h0000_0000);
    reg_check("status kept", instr_exec_pkg::REG_STATUS, 32'h0000_001F);
    chk("file copy data", 32'h0000_0033, {24'h0, mem[12'h000]});
    chk("file copy address", 32'h0000_0000, {20'h0, wr_addr});
    chk("read to write distance", 32'h0000_0005, 32'(wr_gap));
    end_of_test;
  end

endmodule : tb

`default_nettype wire
